// ---- bench/lcfs_asserts.sv ----
`timescale 1ns/100ps
module lcfs_asserts
(
   input wire logic CLK,
   input wire logic RST_B,
   input wire logic cmd_valid,
   input wire logic cmd_ready,
   input wire lcfs_pkg::lcfs_op_e cmd_op,
   input wire logic [lcfs_pkg::LCFS_CHAN_W-1:0] cmd_chan,
   input wire logic cmd_prot,
   input wire logic rsp_valid,
   input wire logic [15:0] rsp_sw,
   input wire logic [7:0] rsp_data
);
   import lcfs_pkg::*;
   // ==========================================================
   // Helper state
   lcfs_op_e last_op;
   logic p2p_seen;
   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (!RST_B);
   always_ff @(posedge CLK or negedge RST_B)
   begin
      if (!RST_B)
         last_op <= LCFS_OP_OPEN;
      else if (cmd_valid && cmd_ready)
         last_op <= cmd_op;
   end
   // Platform mode only ends at reset, so a sticky flag is enough
   always_ff @(posedge CLK or negedge RST_B)
   begin
      if (!RST_B)
         p2p_seen <= 1'b0;
      else if (rsp_valid && rsp_sw == LCFS_SW_OK && last_op == LCFS_OP_SEC_P2P)
         p2p_seen <= 1'b1;
   end
   // ==========================================================
   // Link checks
   sequence s_take;
      cmd_valid && cmd_ready;
   endsequence
   sequence s_open_ok;
      cmd_valid && cmd_ready && cmd_op == LCFS_OP_OPEN ##2 rsp_sw == LCFS_SW_OK;
   endsequence
   a_answer_two_cycles: assert property (s_take |-> ##2 rsp_valid)
      else $error("No answer two cycles after a take");
   a_busy_until_answer: assert property (s_take |=> !cmd_ready ##1 cmd_ready)
      else $error("Card not busy for exactly the command");
   a_answer_has_cause: assert property (rsp_valid |-> $past(cmd_valid && cmd_ready, 2))
      else $error("Answer without a command");
   a_single_answer: assert property (rsp_valid |=> !rsp_valid)
      else $error("Answer longer than one cycle");
   a_bad_chan_refused: assert property ((s_take ##0 (cmd_chan > 5'h13))
      |-> ##2 rsp_sw == LCFS_SW_BAD_CHAN)
      else $error("Channel above range not refused");
   a_basic_stays_open: assert property ((s_take ##0 (cmd_op == LCFS_OP_CLOSE && cmd_chan == 5'h00))
      |-> ##2 rsp_sw != LCFS_SW_OK)
      else $error("Channel zero closed");
   a_open_number_range: assert property (s_open_ok |-> rsp_data >= 8'h01 && rsp_data <= 8'h13)
      else $error("Open returned a bad channel number");
   a_a2a_off_basic: assert property ((s_take ##0 (cmd_op == LCFS_OP_SEC_A2A)) |-> cmd_chan != 5'h00)
      else $error("Application secure channel sent on channel zero");
   a_p2p_on_basic: assert property ((s_take ##0 (cmd_op == LCFS_OP_SEC_P2P)) |-> cmd_chan == 5'h00)
      else $error("Platform secure channel sent off channel zero");
   a_p2p_protected: assert property ((s_take ##0 (p2p_seen && !(cmd_op inside {LCFS_OP_SEC_A2A,
      LCFS_OP_SEC_P2P, LCFS_OP_TRANSACT, LCFS_OP_GET_RESP}))) |-> cmd_prot)
      else $error("Unprotected command in platform secure mode");
endmodule

// ---- bench/tb.sv ----
`timescale 1ns/100ps
module tb;
   import lcfs_pkg::*;
   logic CLK = 1'b0;
   logic RST_B = 1'b0;
   logic REQ_VALID = 1'b0;
   lcfs_op_e REQ_OP = LCFS_OP_OPEN;
   logic [4:0] REQ_CHAN = 5'h00;
   logic [15:0] REQ_FID = 16'h0000;
   logic REQ_SHARE = 1'b0;
   logic REQ_READY;
   logic DONE;
   logic P2P_ACTIVE;
   logic [15:0] DONE_SW;
   logic [7:0] DONE_DATA;
   logic [19:0] OPEN_MASK;
   logic [15:0] got_sw;
   logic [7:0] got_data;
   int mismatches = 0;
   int checked = 0;
   lcfs_if link();
   lcfs_card i_lcfs_card(.CLK(CLK), .RST_B(RST_B), .LINK(link), .OPEN_MASK(OPEN_MASK), .P2P_ACTIVE(P2P_ACTIVE));
   lcfs_term i_lcfs_term(.CLK(CLK), .RST_B(RST_B), .LINK(link), .REQ_VALID(REQ_VALID), .REQ_OP(REQ_OP),
      .REQ_CHAN(REQ_CHAN), .REQ_FID(REQ_FID), .REQ_SHARE(REQ_SHARE), .REQ_READY(REQ_READY), .DONE(DONE),
      .DONE_SW(DONE_SW), .DONE_DATA(DONE_DATA));
   lcfs_asserts i_lcfs_asserts(.CLK(CLK), .RST_B(RST_B), .cmd_valid(link.cmd_valid), .cmd_ready(link.cmd_ready),
      .cmd_op(link.cmd_op), .cmd_chan(link.cmd_chan), .cmd_prot(link.cmd_prot), .rsp_valid(link.rsp_valid),
      .rsp_sw(link.rsp_sw), .rsp_data(link.rsp_data));
   always #5 CLK = ~CLK;
   // ==========================================================
   // Shared tasks
   task automatic tally_and_finish();
      if (mismatches == 0 && checked > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task automatic chk(input logic [19:0] seen, input logic [19:0] exp);
      checked++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("ERROR %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   // Entered just after an edge; the request holds until the edge that takes it
   task automatic cmd(input lcfs_op_e op, input logic [4:0] ch, input logic [15:0] file_identifier, input logic sh);
      int n;
      logic tk;
      REQ_VALID = 1'b1;
      REQ_OP = op;
      REQ_CHAN = ch;
      REQ_FID = file_identifier;
      REQ_SHARE = sh;
      n = 0;
      tk = 1'b0;
      // Ready is judged before the edge, while it is settled
      while (!tk && n < 20)
      begin
         tk = (REQ_READY === 1'b1);
         @(posedge CLK);
         n++;
         #1;
      end
      REQ_VALID = 1'b0;
      while (DONE !== 1'b1 && n < 40)
      begin
         @(posedge CLK);
         n++;
         #1;
      end
      if (n >= 40)
      begin
         mismatches++;
         tally_and_finish();
      end
      got_sw = DONE_SW;
      got_data = DONE_DATA;
   endtask
   // ==========================================================
   // Scenarios
   task automatic run_basic();
      chk(OPEN_MASK, 20'h0_0001);
      chk(P2P_ACTIVE, 1'b0);
      cmd(LCFS_OP_CLOSE, 5'h00, 16'h0000, 1'b0);
      chk(got_sw, LCFS_SW_NOT_ALLOWED);
      cmd(LCFS_OP_OPEN, 5'h00, 16'h0000, 1'b0);
      chk(got_data, 8'h01);
      cmd(LCFS_OP_OPEN, 5'h00, 16'h0000, 1'b0);
      chk(got_data, 8'h02);
      chk(OPEN_MASK, 20'h0_0007);
   endtask
   task automatic run_share();
      cmd(LCFS_OP_SEL_LEAF, 5'h01, 16'h2F11, 1'b1);
      chk(got_sw, LCFS_SW_OK);
      cmd(LCFS_OP_SEL_LEAF, 5'h02, 16'h2F11, 1'b1);
      chk(got_sw, LCFS_SW_OK);
      cmd(LCFS_OP_SEL_LEAF, 5'h01, 16'h2F10, 1'b0);
      chk(got_sw, LCFS_SW_OK);
      cmd(LCFS_OP_SEL_LEAF, 5'h02, 16'h2F10, 1'b0);
      chk(got_sw, LCFS_SW_COND_USE);
      cmd(LCFS_OP_RECORD, 5'h01, 16'h0000, 1'b0);
      chk(got_data, 8'h00);
      cmd(LCFS_OP_RECORD, 5'h01, 16'h0000, 1'b0);
      chk(got_data, 8'h01);
      cmd(LCFS_OP_RECORD, 5'h02, 16'h0000, 1'b0);
      chk(got_data, 8'h00);
   endtask
   task automatic run_dirs();
      cmd(LCFS_OP_OPEN, 5'h00, 16'h0000, 1'b0);
      cmd(LCFS_OP_SEL_DIR, 5'h03, 16'h5F10, 1'b0);
      cmd(LCFS_OP_OPEN, 5'h03, 16'h0000, 1'b0);
      chk(got_sw, LCFS_SW_NOT_ALLOWED);
      chk(OPEN_MASK, 20'h0_000F);
      cmd(LCFS_OP_SEL_DIR, 5'h03, 16'h5F20, 1'b1);
      cmd(LCFS_OP_SEL_APP, 5'h03, 16'h7F50, 1'b1);
      cmd(LCFS_OP_OPEN, 5'h03, 16'h0000, 1'b0);
      chk(got_data, 8'h04);
      cmd(LCFS_OP_RECORD, 5'h04, 16'h0000, 1'b0);
      chk(got_sw, LCFS_SW_NOT_ALLOWED);
      cmd(LCFS_OP_SEL_DIR, 5'h04, LCFS_FID_CUR_APP, 1'b1);
      chk(got_sw, LCFS_SW_OK);
      cmd(LCFS_OP_OPEN, 5'h00, 16'h0000, 1'b0);
      cmd(LCFS_OP_SEL_DIR, 5'h05, LCFS_FID_CUR_APP, 1'b1);
      chk(got_sw, LCFS_SW_NOT_FOUND);
   endtask
   task automatic run_fill();
      for (int i = 6; i <= 19; i++)
      begin
         cmd(LCFS_OP_OPEN, 5'h00, 16'h0000, 1'b0);
         chk(got_data, i[7:0]);
      end
      chk(OPEN_MASK, 20'hF_FFFF);
      cmd(LCFS_OP_OPEN, 5'h00, 16'h0000, 1'b0);
      chk(got_sw, LCFS_SW_NO_FUNC);
      cmd(LCFS_OP_CLOSE, 5'h05, 16'h0000, 1'b0);
      chk(OPEN_MASK, 20'hF_FFDF);
      cmd(LCFS_OP_RECORD, 5'h05, 16'h0000, 1'b0);
      chk(got_sw, LCFS_SW_BAD_CHAN);
      cmd(LCFS_OP_RECORD, 5'h14, 16'h0000, 1'b0);
      chk(got_sw, LCFS_SW_BAD_CHAN);
      cmd(LCFS_OP_OPEN, 5'h00, 16'h0000, 1'b0);
      chk(got_data, 8'h05);
   endtask
   task automatic run_secure();
      cmd(LCFS_OP_SEC_A2A, 5'h00, 16'h0000, 1'b0);
      chk(got_sw, LCFS_SW_NOT_ALLOWED);
      cmd(LCFS_OP_SEC_A2A, 5'h01, 16'h0000, 1'b0);
      chk(got_sw, LCFS_SW_OK);
      cmd(LCFS_OP_SEC_P2P, 5'h01, 16'h0000, 1'b0);
      chk(got_sw, LCFS_SW_NOT_ALLOWED);
      cmd(LCFS_OP_SEC_P2P, 5'h00, 16'h0000, 1'b0);
      chk(P2P_ACTIVE, 1'b1);
      cmd(LCFS_OP_SEL_DIR, 5'h02, 16'h5F30, 1'b1);
      chk(got_sw, LCFS_SW_OK);
   endtask
   initial
   begin
      repeat (5) @(posedge CLK);
      #1;
      RST_B = 1'b1;
      run_basic();
      run_share();
      run_dirs();
      run_fill();
      run_secure();
      tally_and_finish();
   end
endmodule

// ---- core/lcfs_card.sv ----
`timescale 1ns/100ps
module lcfs_card
#(
   parameter int N_EXTRA = lcfs_pkg::LCFS_EXTRA_CHANNELS
)
(
   input wire logic CLK,
   input wire logic RST_B,
   lcfs_if.card LINK,
   output logic [N_EXTRA:0] OPEN_MASK,
   output logic P2P_ACTIVE
);
   import lcfs_pkg::*;

   typedef enum logic {LCFS_ST_IDLE, LCFS_ST_EXEC} lcfs_state_e;

   localparam int N_CH = N_EXTRA + 1;

   lcfs_state_e state;
   lcfs_op_e c_op;
   logic [LCFS_CHAN_W-1:0] c_chan;
   logic [LCFS_FID_W-1:0] c_fid;
   logic c_share;
   logic c_prot;

   // Per-channel context, one slot per channel
   logic [LCFS_FID_W-1:0] cur_dir [N_CH];
   logic dir_share [N_CH];
   logic [LCFS_FID_W-1:0] app_dir [N_CH];
   logic app_valid [N_CH];
   logic app_share [N_CH];
   logic [LCFS_FID_W-1:0] leaf [N_CH];
   logic leaf_valid [N_CH];
   logic leaf_share [N_CH];
   logic [LCFS_REC_W-1:0] rec_ptr [N_CH];
   logic a2a [N_CH];

   logic [15:0] next_sw;
   logic [7:0] next_data;
   logic commit;
   logic [LCFS_CHAN_W-1:0] free_ch;
   logic held;

   // Lowest closed channel above zero, zero when all are in use
   function automatic logic [LCFS_CHAN_W-1:0] first_free(input logic [N_EXTRA:0] mask);
      logic [LCFS_CHAN_W-1:0] r;
      r = '0;
      for (int i = N_EXTRA; i >= 1; i--)
      begin
         if (!mask[i])
            r = LCFS_CHAN_W'(i);
      end
      return r;
   endfunction

   // True when another channel holds the file without sharing it
   function automatic logic held_elsewhere(input logic [LCFS_FID_W-1:0] file_identifier, input logic [LCFS_CHAN_W-1:0] ch);
      logic h;
      h = 1'b0;
      for (int i = 0; i < N_CH; i++)
      begin
         if (OPEN_MASK[i] && (LCFS_CHAN_W'(i) != ch))
         begin
            if (leaf_valid[i] && leaf[i] == file_identifier && !leaf_share[i])
               h = 1'b1;
            if (cur_dir[i] == file_identifier && !dir_share[i])
               h = 1'b1;
            if (app_valid[i] && app_dir[i] == file_identifier && !app_share[i])
               h = 1'b1;
         end
      end
      return h;
   endfunction

   assign free_ch = first_free(OPEN_MASK);
   // A plain assign would miss table changes that the function reads
   always_comb
   begin
      held = held_elsewhere(c_fid, c_chan);
   end

   // ==========================================================
   // Handshake: a new command is taken only after the last answer
   always_ff @(posedge CLK or negedge RST_B)
   begin
      if (!RST_B)
      begin
         state <= LCFS_ST_IDLE;
         LINK.cmd_ready <= 1'b1;
         c_op <= LCFS_OP_GET_RESP;
         c_chan <= '0;
         c_fid <= '0;
         c_share <= 1'b0;
         c_prot <= 1'b0;
      end
      else
      begin
         case (state)
            LCFS_ST_IDLE:
            begin
               if (LINK.cmd_valid && LINK.cmd_ready)
               begin
                  c_op <= LINK.cmd_op;
                  c_chan <= LINK.cmd_chan;
                  c_fid <= LINK.cmd_fid;
                  c_share <= LINK.cmd_share;
                  c_prot <= LINK.cmd_prot;
                  LINK.cmd_ready <= 1'b0;
                  state <= LCFS_ST_EXEC;
               end
            end
            default:
            begin
               LINK.cmd_ready <= 1'b1;
               state <= LCFS_ST_IDLE;
            end
         endcase
      end
   end

   // ==========================================================
   // Command decision
   always_comb
   begin
      next_sw = LCFS_SW_OK;
      next_data = 8'h00;
      if (32'(c_chan) > N_EXTRA || !OPEN_MASK[c_chan])
         next_sw = LCFS_SW_BAD_CHAN;
      else if (P2P_ACTIVE && !c_prot && !lcfs_exempt(c_op))
         next_sw = LCFS_SW_SEC_STATUS;
      else
      begin
         case (c_op)
            LCFS_OP_OPEN:
            begin
               if (!dir_share[c_chan] || (app_valid[c_chan] && !app_share[c_chan]))
                  next_sw = LCFS_SW_NOT_ALLOWED;
               else if (free_ch == '0)
                  next_sw = LCFS_SW_NO_FUNC;
               else
                  next_data = 8'(free_ch);
            end
            LCFS_OP_CLOSE:
               if (c_chan == '0)
                  next_sw = LCFS_SW_NOT_ALLOWED;
            LCFS_OP_SEL_DIR:
               if (c_fid == LCFS_FID_CUR_APP && !app_valid[c_chan])
                  next_sw = LCFS_SW_NOT_FOUND;
               else if (c_fid != LCFS_FID_CUR_APP && held)
                  next_sw = LCFS_SW_COND_USE;
            LCFS_OP_SEL_APP, LCFS_OP_SEL_LEAF:
               if (held)
                  next_sw = LCFS_SW_COND_USE;
            LCFS_OP_RECORD:
            begin
               if (!leaf_valid[c_chan])
                  next_sw = LCFS_SW_NOT_ALLOWED;
               else
                  next_data = 8'(rec_ptr[c_chan]);
            end
            LCFS_OP_SEC_A2A:
               if (c_chan == '0)
                  next_sw = LCFS_SW_NOT_ALLOWED;
            LCFS_OP_SEC_P2P:
               if (c_chan != '0)
                  next_sw = LCFS_SW_NOT_ALLOWED;
            default:
               next_sw = LCFS_SW_OK;
         endcase
      end
   end

   assign commit = (state == LCFS_ST_EXEC) && (next_sw == LCFS_SW_OK);

   // ==========================================================
   // Response
   always_ff @(posedge CLK or negedge RST_B)
   begin
      if (!RST_B)
      begin
         LINK.rsp_valid <= 1'b0;
         LINK.rsp_sw <= LCFS_SW_OK;
         LINK.rsp_data <= 8'h00;
      end
      else
      begin
         LINK.rsp_valid <= (state == LCFS_ST_EXEC);
         if (state == LCFS_ST_EXEC)
         begin
            LINK.rsp_sw <= next_sw;
            LINK.rsp_data <= next_data;
         end
      end
   end

   // ==========================================================
   // Channel table; only the addressed channel's slot changes, except open, which sets up the slot at free_ch
   always_ff @(posedge CLK or negedge RST_B)
   begin
      if (!RST_B)
      begin
         OPEN_MASK <= {{N_EXTRA{1'b0}}, 1'b1};
         P2P_ACTIVE <= 1'b0;
         for (int i = 0; i < N_CH; i++)
         begin
            cur_dir[i] <= LCFS_FID_ROOT;
            dir_share[i] <= LCFS_ROOT_SHARE_RST;
            app_dir[i] <= '0;
            app_valid[i] <= 1'b0;
            app_share[i] <= 1'b0;
            leaf[i] <= '0;
            leaf_valid[i] <= 1'b0;
            leaf_share[i] <= 1'b0;
            rec_ptr[i] <= '0;
            a2a[i] <= 1'b0;
         end
      end
      else if (commit)
      begin
         case (c_op)
            LCFS_OP_OPEN:
            begin
               OPEN_MASK[free_ch] <= 1'b1;
               leaf_valid[free_ch] <= 1'b0;
               rec_ptr[free_ch] <= '0;
               a2a[free_ch] <= 1'b0;
               if (c_chan == '0)
               begin
                  cur_dir[free_ch] <= LCFS_FID_ROOT;
                  dir_share[free_ch] <= LCFS_ROOT_SHARE_RST;
                  app_valid[free_ch] <= 1'b0;
               end
               else
               begin
                  cur_dir[free_ch] <= cur_dir[c_chan];
                  dir_share[free_ch] <= dir_share[c_chan];
                  app_dir[free_ch] <= app_dir[c_chan];
                  app_valid[free_ch] <= app_valid[c_chan];
                  app_share[free_ch] <= app_share[c_chan];
               end
            end
            LCFS_OP_CLOSE:
            begin
               OPEN_MASK[c_chan] <= 1'b0;
               leaf_valid[c_chan] <= 1'b0;
               app_valid[c_chan] <= 1'b0;
               a2a[c_chan] <= 1'b0;
               // A closed slot must not keep a directory locked
               cur_dir[c_chan] <= LCFS_FID_ROOT;
               dir_share[c_chan] <= LCFS_ROOT_SHARE_RST;
            end
            LCFS_OP_SEL_DIR:
            begin
               if (c_fid == LCFS_FID_CUR_APP)
               begin
                  cur_dir[c_chan] <= app_dir[c_chan];
                  dir_share[c_chan] <= app_share[c_chan];
               end
               else
               begin
                  cur_dir[c_chan] <= c_fid;
                  dir_share[c_chan] <= c_share;
               end
               leaf_valid[c_chan] <= 1'b0;
            end
            LCFS_OP_SEL_APP:
            begin
               app_dir[c_chan] <= c_fid;
               app_valid[c_chan] <= 1'b1;
               app_share[c_chan] <= c_share;
               cur_dir[c_chan] <= c_fid;
               dir_share[c_chan] <= c_share;
               leaf_valid[c_chan] <= 1'b0;
            end
            LCFS_OP_SEL_LEAF:
            begin
               leaf[c_chan] <= c_fid;
               leaf_valid[c_chan] <= 1'b1;
               leaf_share[c_chan] <= c_share;
               rec_ptr[c_chan] <= '0;
            end
            LCFS_OP_RECORD:
               rec_ptr[c_chan] <= rec_ptr[c_chan] + 1'b1;
            LCFS_OP_SEC_A2A:
               a2a[c_chan] <= 1'b1;
            LCFS_OP_SEC_P2P:
               P2P_ACTIVE <= 1'b1;
            default:
               P2P_ACTIVE <= P2P_ACTIVE;
         endcase
      end
   end
endmodule

// ---- core/lcfs_if.sv ----
`timescale 1ns/100ps
interface lcfs_if;
   import lcfs_pkg::*;
   logic cmd_valid;
   logic cmd_ready;
   lcfs_op_e cmd_op;
   logic [LCFS_CHAN_W-1:0] cmd_chan;
   logic [LCFS_FID_W-1:0] cmd_fid;
   logic cmd_share;
   logic cmd_prot;
   logic rsp_valid;
   logic [15:0] rsp_sw;
   logic [7:0] rsp_data;

   modport card
   (
      input cmd_valid, cmd_op, cmd_chan, cmd_fid, cmd_share, cmd_prot,
      output cmd_ready, rsp_valid, rsp_sw, rsp_data
   );
   modport term
   (
      output cmd_valid, cmd_op, cmd_chan, cmd_fid, cmd_share, cmd_prot,
      input cmd_ready, rsp_valid, rsp_sw, rsp_data
   );
endinterface

// ---- core/lcfs_pkg.sv ----
package lcfs_pkg;
   // ==========================================================
   // Channel geometry
   localparam int LCFS_EXTRA_CHANNELS = 19;
   localparam int LCFS_CHAN_W = 5;
   localparam int LCFS_FID_W = 16;
   localparam int LCFS_REC_W = 8;
   // ==========================================================
   // File identifiers and reset values
   localparam logic [15:0] LCFS_FID_ROOT = 16'h3F00;
   localparam logic [15:0] LCFS_FID_CUR_APP = 16'h7FFF;
   localparam logic LCFS_ROOT_SHARE_RST = 1'b1;
   // ==========================================================
   // Status words
   localparam logic [15:0] LCFS_SW_OK = 16'h9000;
   localparam logic [15:0] LCFS_SW_COND_USE = 16'h6985;
   localparam logic [15:0] LCFS_SW_NOT_ALLOWED = 16'h6986;
   localparam logic [15:0] LCFS_SW_SEC_STATUS = 16'h6982;
   localparam logic [15:0] LCFS_SW_BAD_CHAN = 16'h6881;
   localparam logic [15:0] LCFS_SW_NO_FUNC = 16'h6A81;
   localparam logic [15:0] LCFS_SW_NOT_FOUND = 16'h6A82;
   // ==========================================================
   // Command set
   typedef enum logic [3:0]
   {
      LCFS_OP_OPEN,
      LCFS_OP_CLOSE,
      LCFS_OP_SEL_DIR,
      LCFS_OP_SEL_APP,
      LCFS_OP_SEL_LEAF,
      LCFS_OP_RECORD,
      LCFS_OP_SEC_A2A,
      LCFS_OP_SEC_P2P,
      LCFS_OP_TRANSACT,
      LCFS_OP_GET_RESP
   } lcfs_op_e;

   function automatic logic lcfs_exempt(input lcfs_op_e op);
      return (op == LCFS_OP_SEC_A2A) || (op == LCFS_OP_SEC_P2P) ||
             (op == LCFS_OP_TRANSACT) || (op == LCFS_OP_GET_RESP);
   endfunction
endpackage

// ---- core/lcfs_term.sv ----
`timescale 1ns/100ps
module lcfs_term
(
   input wire logic CLK,
   input wire logic RST_B,
   lcfs_if.term LINK,
   input wire logic REQ_VALID,
   input wire lcfs_pkg::lcfs_op_e REQ_OP,
   input wire logic [lcfs_pkg::LCFS_CHAN_W-1:0] REQ_CHAN,
   input wire logic [lcfs_pkg::LCFS_FID_W-1:0] REQ_FID,
   input wire logic REQ_SHARE,
   output logic REQ_READY,
   output logic DONE,
   output logic [15:0] DONE_SW,
   output logic [7:0] DONE_DATA
);
   import lcfs_pkg::*;

   typedef enum logic [1:0] {LCFS_T_IDLE, LCFS_T_SEND, LCFS_T_WAIT} lcfs_tstate_e;

   lcfs_tstate_e state;
   logic p2p_on;
   logic local_reject;

   // Secure-channel placement is checked here so the card never sees it
   assign local_reject = ((REQ_OP == LCFS_OP_SEC_P2P) && (REQ_CHAN != '0)) ||
                         ((REQ_OP == LCFS_OP_SEC_A2A) && (REQ_CHAN == '0));

   // ==========================================================
   // One command outstanding at a time
   always_ff @(posedge CLK or negedge RST_B)
   begin
      if (!RST_B)
      begin
         state <= LCFS_T_IDLE;
         REQ_READY <= 1'b1;
         DONE <= 1'b0;
         DONE_SW <= LCFS_SW_OK;
         DONE_DATA <= 8'h00;
         LINK.cmd_valid <= 1'b0;
         LINK.cmd_op <= LCFS_OP_GET_RESP;
         LINK.cmd_chan <= '0;
         LINK.cmd_fid <= '0;
         LINK.cmd_share <= 1'b0;
         LINK.cmd_prot <= 1'b0;
         p2p_on <= 1'b0;
      end
      else
      begin
         DONE <= 1'b0;
         case (state)
            LCFS_T_IDLE:
            begin
               if (REQ_VALID && REQ_READY)
               begin
                  REQ_READY <= 1'b0;
                  if (local_reject)
                  begin
                     DONE <= 1'b1;
                     DONE_SW <= LCFS_SW_NOT_ALLOWED;
                     DONE_DATA <= 8'h00;
                     REQ_READY <= 1'b1;
                  end
                  else
                  begin
                     LINK.cmd_valid <= 1'b1;
                     LINK.cmd_op <= REQ_OP;
                     LINK.cmd_chan <= REQ_CHAN;
                     LINK.cmd_fid <= REQ_FID;
                     LINK.cmd_share <= REQ_SHARE;
                     LINK.cmd_prot <= p2p_on && !lcfs_exempt(REQ_OP);
                     state <= LCFS_T_SEND;
                  end
               end
            end
            LCFS_T_SEND:
            begin
               if (LINK.cmd_ready)
               begin
                  LINK.cmd_valid <= 1'b0;
                  state <= LCFS_T_WAIT;
               end
            end
            default:
            begin
               if (LINK.rsp_valid)
               begin
                  DONE <= 1'b1;
                  DONE_SW <= LINK.rsp_sw;
                  DONE_DATA <= LINK.rsp_data;
                  REQ_READY <= 1'b1;
                  state <= LCFS_T_IDLE;
                  if (LINK.cmd_op == LCFS_OP_SEC_P2P && LINK.rsp_sw == LCFS_SW_OK)
                     p2p_on <= 1'b1;
               end
            end
         endcase
      end
   end
endmodule
